/* inc/ceu_regs.vh */
`ifndef CEU_REGS_VH
`define CEU_REGS_VH

// Vector offsets ORed onto the vector base.
`define CEU_OFS_DWADDR 32'h0000_0038
`define CEU_OFS_DRMISS 32'h0000_0060
`define CEU_OFS_DWMISS 32'h0000_0070
`define CEU_OFS_DRPROT 32'h0000_003c
`define CEU_OFS_DWPROT 32'h0000_0040
`define CEU_OFS_DMOD 32'h0000_0044
`define CEU_OFS_PRIV 32'h0000_0028
`define CEU_OFS_FPE 32'h0000_002c
`define CEU_OFS_COP 32'h0000_0030
`define CEU_OFS_SCALL 32'h0000_0100

// Mode field encodings.
`define CEU_MODE_APP 3'h0
`define CEU_MODE_SUP 3'h1
`define CEU_MODE_INT0 3'h2
`define CEU_MODE_INT1 3'h3
`define CEU_MODE_INT2 3'h4
`define CEU_MODE_LEVEL3_IRQ 3'h5
`define CEU_MODE_EXC 3'h6
`define CEU_MODE_NMI 3'h7

// Status register field positions.
`define CEU_SR_R 15
`define CEU_SR_J 28
`define CEU_SR_GM 16
`define CEU_SR_I0M 17
`define CEU_SR_EM 21
`define CEU_SR_M_LO 22
`define CEU_SR_M_HI 24
`define CEU_SR_RESET 32'h01c1_0000

// Entry high register: instruction-side flag and virtual page field.
`define CEU_EH_I 1
`define CEU_VPN_LO 10

// Latency figures in cycles.
`define CEU_VEC_FETCH_CYC 4
`define CEU_MAX_DRAIN_CYC 10

// APB register byte addresses.
`define CEU_A_STATUS 12'h000
`define CEU_A_VBASE 12'h004
`define CEU_A_EXCSR 12'h008
`define CEU_A_EXCRA 12'h00c
`define CEU_A_SUPSR 12'h010
`define CEU_A_SUPRA 12'h014
`define CEU_A_FADDR 12'h018
`define CEU_A_EHIGH 12'h01c
`define CEU_A_LINK 12'h020
`define CEU_A_INFO 12'h024
`define CEU_A_SHADOW 12'h028

`endif

/* core/ceu_priv_check.v */
`timescale 1ns/10ps
`include "ceu_regs.vh"
// Flags privileged instructions issued from application mode.
module ceu_priv_check
(
	// Decoded instruction class
	input wire ins_cache,
	input wire ins_entry_read,
	input wire ins_entry_write,
	input wire ins_entry_search,
	input wire ins_mtdr,
	input wire ins_mfdr,
	input wire ins_rete,
	input wire ins_rets,
	input wire ins_retd,
	input wire ins_sleep,
	input wire ins_csrf,
	input wire ins_ssrf,
	input wire ins_mtsr,
	input wire ins_mfsr,
	// Operand detail
	input wire [4:0] flag_bit,
	input wire sysreg_is_bytecode,
	input wire [2:0] mode,
	// Result
	output wire violation
);
	wire always_priv;
	wire flag_priv;
	wire sysreg_priv;

	assign always_priv = ins_cache | ins_entry_read | ins_entry_write |
		ins_entry_search | ins_mtdr | ins_mfdr | ins_rete | ins_rets |
		ins_retd | ins_sleep;
	// Only the upper status half is guarded.
	assign flag_priv = (ins_csrf | ins_ssrf) & flag_bit[4];
	assign sysreg_priv = (ins_mtsr | ins_mfsr) & ~sysreg_is_bytecode;
	assign violation = (mode == `CEU_MODE_APP) &
		(always_priv | flag_priv | sysreg_priv);
endmodule // ceu_priv_check

/* core/ceu_irq_lat.v */
`timescale 1ns/10ps
`include "ceu_regs.vh"
// Interrupt latency sequencer: drain, then fixed vector fetch.
module ceu_irq_lat
(
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Control
	input wire start,
	input wire pipe_busy,
	// Status
	output wire idle,
	output reg handler_go
);
	localparam S_IDLE = 3'b001;
	localparam S_DRAIN = 3'b010;
	localparam S_FETCH = 3'b100;

	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [2:0] cnt_r;
	reg [2:0] cnt_nxt;

	assign idle = state_r[0];

	always @*
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		handler_go = 1'b0;
		case (state_r)
		S_IDLE:
			if (start)
			begin
				state_nxt = S_DRAIN;
			end
		S_DRAIN:
			// Cache refills simply stretch the busy time.
			if (!pipe_busy)
			begin
				state_nxt = S_FETCH;
				cnt_nxt = 3'h0;
			end
		S_FETCH:
			if (cnt_r == `CEU_VEC_FETCH_CYC - 1)
			begin
				state_nxt = S_IDLE;
				handler_go = 1'b1;
			end
			else
			begin
				cnt_nxt = cnt_r + 3'h1;
			end
		default:
			state_nxt = S_IDLE;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= S_IDLE;
			cnt_r <= 3'h0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule // ceu_irq_lat

/* core/ceu_top.v */
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`include "ceu_regs.vh"
// Operation
// - Misaligned write: save, mode 110, EM, 0x38
// - Read translation miss: record, clear I, 0x60
// - Write translation miss: record, clear I, 0x70
// - Read protection fault: record, clear I, 0x3C
// - Write protection fault: record, clear I, 0x40
// - Write to clean page: record, clear I, 0x44
// - Application privileged instruction: EM, GM, 0x28
// - Listed system instructions need privileged mode
// - Flag ops privileged only upper half
// - System moves privileged except bytecode registers
// - Floating-point error: EM, GM, 0x2C
// - Unacknowledged coprocessor instruction: EM, GM, 0x30
// - Return from supervisor resumes after call
// - Four autovectored levels plus non-maskable
// - Level three uses shadowed register context
// - Interrupts wait for drained pipeline stages
// - Worst latency ten drain plus four
// - Empty pipeline gives four-cycle latency
// - Cache refill extends interrupt latency
// - Global or level mask blocks; accept sets mask
module ceu_top
(
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Pipeline exception causes
	input wire [31:0] cur_pc,
	input wire [31:0] fail_addr,
	input wire dw_misalign,
	input wire dr_miss,
	input wire dw_miss,
	input wire dr_prot,
	input wire dw_prot,
	input wire dw_clean,
	input wire fpu_error,
	input wire cop_issue,
	input wire cop_ack,
	input wire scall_exec,
	input wire rets_exec,
	// Instruction classes for privilege check
	input wire ins_cache,
	input wire ins_entry_read,
	input wire ins_entry_write,
	input wire ins_entry_search,
	input wire ins_mtdr,
	input wire ins_mfdr,
	input wire ins_rete,
	input wire ins_rets,
	input wire ins_retd,
	input wire ins_sleep,
	input wire ins_csrf,
	input wire ins_ssrf,
	input wire ins_mtsr,
	input wire ins_mfsr,
	input wire [4:0] flag_bit,
	input wire sysreg_is_bytecode,
	// Interrupt controller
	input wire [3:0] irq_req,
	input wire nmi_req,
	input wire [31:0] irq_offset,
	input wire pipe_busy,
	// Flow change toward fetch
	output reg pc_load,
	output reg [31:0] pc_target,
	output reg shadow_ctx
);
	//**********************************************************
	// Registers
	//**********************************************************
	reg [31:0] status_reg_r;
	reg [31:0] vector_base_r;
	reg [31:0] exc_status_copy_r;
	reg [31:0] exc_return_addr_r;
	reg [31:0] sup_status_copy_r;
	reg [31:0] sup_return_addr_r;
	reg [31:0] fault_addr_reg_r;
	reg [31:0] entry_high_reg_r;
	reg [31:0] link_reg_r;
	reg [2:0] irq_level_r;
	reg irq_nmi_r;
	reg [2:0] nmi_sync_r;
	reg [3:0] irq_s1_r;
	reg [3:0] irq_s2_r;
	reg [3:0] irq_s3_r;

	wire priv_viol;
	wire lat_idle;
	wire handler_go;
	wire [2:0] mode;
	wire apb_wr;
	wire nmi_ok;
	wire [3:0] irq_ok;
	wire irq_any;
	wire nmi_s;

	assign mode = status_reg_r[`CEU_SR_M_HI:`CEU_SR_M_LO];
	assign apb_wr = psel & penable & pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	// Pick the highest unmasked level.
	function [2:0] pick_level;
		input [3:0] req;
		begin
			if (req[3])
				pick_level = 3'h3;
			else if (req[2])
				pick_level = 3'h2;
			else if (req[1])
				pick_level = 3'h1;
			else
				pick_level = 3'h0;
		end
	endfunction

	// Status image on a common exception entry.
	function [31:0] exc_sr;
		input [31:0] sr;
		input gm;
		reg [31:0] t;
		begin
			t = sr;
			t[`CEU_SR_R] = 1'b0;
			t[`CEU_SR_J] = 1'b0;
			t[`CEU_SR_M_HI:`CEU_SR_M_LO] = `CEU_MODE_EXC;
			t[`CEU_SR_EM] = 1'b1;
			if (gm)
				t[`CEU_SR_GM] = 1'b1;
			exc_sr = t;
		end
	endfunction

	//**********************************************************
	// Privilege check and latency sequencer
	//**********************************************************
	ceu_priv_check u_priv
	(
		.ins_cache(ins_cache),
		.ins_entry_read(ins_entry_read),
		.ins_entry_write(ins_entry_write),
		.ins_entry_search(ins_entry_search),
		.ins_mtdr(ins_mtdr),
		.ins_mfdr(ins_mfdr),
		.ins_rete(ins_rete),
		.ins_rets(ins_rets),
		.ins_retd(ins_retd),
		.ins_sleep(ins_sleep),
		.ins_csrf(ins_csrf),
		.ins_ssrf(ins_ssrf),
		.ins_mtsr(ins_mtsr),
		.ins_mfsr(ins_mfsr),
		.flag_bit(flag_bit),
		.sysreg_is_bytecode(sysreg_is_bytecode),
		.mode(mode),
		.violation(priv_viol)
	);

	// Interrupt lines come from another block, so they are synchronised.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_s1_r <= 4'h0;
			irq_s2_r <= 4'h0;
			irq_s3_r <= 4'h0;
			nmi_sync_r <= 3'h0;
		end
		else
		begin
			irq_s1_r <= irq_req;
			irq_s2_r <= irq_s1_r;
			irq_s3_r <= irq_s2_r;
			nmi_sync_r <= {nmi_sync_r[1:0], nmi_req};
		end
	end

	assign nmi_s = nmi_sync_r[2] & nmi_sync_r[1];
	// A level counts once the last two stages agree.
	assign irq_ok = irq_s3_r & irq_s2_r & ~status_reg_r[20:17] &
		{4{~status_reg_r[`CEU_SR_GM]}};
	assign nmi_ok = nmi_s & (mode != `CEU_MODE_NMI);
	assign irq_any = nmi_ok | (|irq_ok);

	ceu_irq_lat u_lat
	(
		.pclk(pclk),
		.presetn(presetn),
		.start(irq_any & lat_idle),
		.pipe_busy(pipe_busy),
		.idle(lat_idle),
		.handler_go(handler_go)
	);

	//**********************************************************
	// Exception entry
	//**********************************************************
	reg [31:0] ofs;
	reg take;
	reg set_gm;
	reg tlb_rec;
	reg clr_i;
	always @*
	begin
		ofs = 32'h0000_0000;
		take = 1'b1;
		set_gm = 1'b0;
		tlb_rec = 1'b0;
		clr_i = 1'b0;
		// Fixed priority among simultaneous causes.
		if (dw_misalign)
		begin
			ofs = `CEU_OFS_DWADDR;
			tlb_rec = 1'b1;
		end
		else if (dr_miss)
		begin
			ofs = `CEU_OFS_DRMISS;
			tlb_rec = 1'b1;
			clr_i = 1'b1;
		end
		else if (dw_miss)
		begin
			ofs = `CEU_OFS_DWMISS;
			tlb_rec = 1'b1;
			clr_i = 1'b1;
		end
		else if (dr_prot)
		begin
			ofs = `CEU_OFS_DRPROT;
			tlb_rec = 1'b1;
			clr_i = 1'b1;
		end
		else if (dw_prot)
		begin
			ofs = `CEU_OFS_DWPROT;
			tlb_rec = 1'b1;
			clr_i = 1'b1;
		end
		else if (dw_clean)
		begin
			ofs = `CEU_OFS_DMOD;
			tlb_rec = 1'b1;
			clr_i = 1'b1;
		end
		else if (priv_viol)
		begin
			ofs = `CEU_OFS_PRIV;
			set_gm = 1'b1;
		end
		else if (fpu_error)
		begin
			ofs = `CEU_OFS_FPE;
			set_gm = 1'b1;
		end
		else if (cop_issue & ~cop_ack)
		begin
			ofs = `CEU_OFS_COP;
			set_gm = 1'b1;
		end
		else
		begin
			take = 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			status_reg_r <= `CEU_SR_RESET;
			vector_base_r <= 32'h0000_0000;
			exc_status_copy_r <= 32'h0000_0000;
			exc_return_addr_r <= 32'h0000_0000;
			sup_status_copy_r <= 32'h0000_0000;
			sup_return_addr_r <= 32'h0000_0000;
			fault_addr_reg_r <= 32'h0000_0000;
			entry_high_reg_r <= 32'h0000_0000;
			link_reg_r <= 32'h0000_0000;
			irq_level_r <= 3'h0;
			irq_nmi_r <= 1'b0;
			pc_load <= 1'b0;
			pc_target <= 32'h0000_0000;
			shadow_ctx <= 1'b0;
		end
		else
		begin
			pc_load <= 1'b0;
			if (take)
			begin
				exc_status_copy_r <= status_reg_r;
				exc_return_addr_r <= cur_pc;
				status_reg_r <= exc_sr(status_reg_r, set_gm);
				pc_target <= vector_base_r | ofs;
				pc_load <= 1'b1;
				if (tlb_rec)
				begin
					fault_addr_reg_r <= fail_addr;
					entry_high_reg_r[31:`CEU_VPN_LO] <=
						fail_addr[31:`CEU_VPN_LO];
					if (clr_i)
						entry_high_reg_r[`CEU_EH_I] <= 1'b0;
				end
			end
			else if (scall_exec)
			begin
				pc_target <= vector_base_r | `CEU_OFS_SCALL;
				pc_load <= 1'b1;
				if (mode == `CEU_MODE_APP || mode == `CEU_MODE_SUP)
				begin
					sup_return_addr_r <= cur_pc + 32'h2;
					sup_status_copy_r <= status_reg_r;
					status_reg_r[`CEU_SR_M_HI:`CEU_SR_M_LO] <=
						`CEU_MODE_SUP;
				end
				else
				begin
					link_reg_r <= cur_pc + 32'h2;
				end
			end
			else if (rets_exec && mode != `CEU_MODE_APP)
			begin
				status_reg_r <= sup_status_copy_r;
				pc_target <= sup_return_addr_r;
				pc_load <= 1'b1;
			end
			else if (lat_idle && irq_any)
			begin
				// Latch the winner; entry waits for the sequencer.
				irq_nmi_r <= nmi_ok;
				irq_level_r <= pick_level(irq_ok);
				exc_status_copy_r <= status_reg_r;
				exc_return_addr_r <= cur_pc;
			end
			else if (handler_go)
			begin
				pc_load <= 1'b1;
				status_reg_r[`CEU_SR_R] <= 1'b0;
				status_reg_r[`CEU_SR_J] <= 1'b0;
				if (irq_nmi_r)
				begin
					status_reg_r <= exc_sr(status_reg_r, 1'b1) |
						(32'h1 << `CEU_SR_M_LO);
					pc_target <= vector_base_r | 32'h0000_0010;
				end
				else
				begin
					// Accepting a level masks it and all below it.
					status_reg_r[`CEU_SR_I0M+:4] <= status_reg_r[20:17] |
						(4'hf >> (3'h3 - irq_level_r));
					status_reg_r[`CEU_SR_M_HI:`CEU_SR_M_LO] <=
						`CEU_MODE_INT0 + irq_level_r;
					pc_target <= vector_base_r | irq_offset;
					shadow_ctx <= (irq_level_r == 3'h3);
				end
			end
			else if (apb_wr)
			begin
				case (paddr)
				`CEU_A_STATUS: status_reg_r <= pwdata;
				`CEU_A_VBASE: vector_base_r <= pwdata;
				`CEU_A_EXCSR: exc_status_copy_r <= pwdata;
				`CEU_A_EXCRA: exc_return_addr_r <= pwdata;
				`CEU_A_SUPSR: sup_status_copy_r <= pwdata;
				`CEU_A_SUPRA: sup_return_addr_r <= pwdata;
				`CEU_A_EHIGH: entry_high_reg_r <= pwdata;
				`CEU_A_LINK: link_reg_r <= pwdata;
				`CEU_A_SHADOW: shadow_ctx <= pwdata[0];
				default: ;
				endcase
			end
		end
	end

	//**********************************************************
	// APB read mux
	//**********************************************************
	// Captured in the setup cycle, so zero-wait reads still leave a flop.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
			case (paddr)
			`CEU_A_STATUS: prdata <= status_reg_r;
			`CEU_A_VBASE: prdata <= vector_base_r;
			`CEU_A_EXCSR: prdata <= exc_status_copy_r;
			`CEU_A_EXCRA: prdata <= exc_return_addr_r;
			`CEU_A_SUPSR: prdata <= sup_status_copy_r;
			`CEU_A_SUPRA: prdata <= sup_return_addr_r;
			`CEU_A_FADDR: prdata <= fault_addr_reg_r;
			`CEU_A_EHIGH: prdata <= entry_high_reg_r;
			`CEU_A_LINK: prdata <= link_reg_r;
			`CEU_A_INFO: prdata <= {28'h0, ~lat_idle, irq_nmi_r,
				irq_level_r[1:0]};
			`CEU_A_SHADOW: prdata <= {31'h0, shadow_ctx};
			default: prdata <= 32'h0000_0000;
			endcase
	end
endmodule // ceu_top

/* test/ceu_partner.sv */
`timescale 1ns/10ps
// Interrupt controller and coprocessor seen from the core.
module ceu_partner
(
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Bench commands
	input wire [3:0] lvl_cmd,
	input wire cop_cmd,
	input wire cop_nak,
	// Toward the core
	output reg [3:0] irq_req,
	output wire nmi_req,
	output wire [31:0] irq_offset,
	output wire cop_issue,
	output wire cop_ack
);
	assign nmi_req = 1'b0;
	// Level three gets its own handler so a wrong level shows in the target.
	assign irq_offset = irq_req[3] ? 32'h0000_0230 : 32'h0000_0200;
	// Acknowledge comes in the issue cycle unless a refusal is commanded.
	assign cop_issue = cop_cmd;
	assign cop_ack = cop_cmd & ~cop_nak;
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			irq_req <= 4'h0;
		else
			irq_req <= lvl_cmd;
endmodule // ceu_partner

/* test/ceu_top_sva.sv */
`timescale 1ns/10ps
module ceu_top_sva
(
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Causes
	input wire dw_misalign,
	input wire dr_miss,
	input wire dw_miss,
	input wire dr_prot,
	input wire dw_prot,
	input wire dw_clean,
	input wire fpu_error,
	input wire cop_issue,
	input wire cop_ack,
	input wire scall_exec,
	input wire pipe_busy,
	// Flow change
	input wire pc_load,
	input wire [31:0] pc_target,
	input wire shadow_ctx
);
	// Only lone listed causes are judged; priv_viol is not in the set, so priority can still let it win over fpu_error or cop_issue.
	wire one = $onehot({dw_misalign, dr_miss, dw_miss, dr_prot, dw_prot,
		dw_clean, fpu_error, cop_issue, scall_exec});
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_vec(c, o);
		c && one |=> pc_load && pc_target[8:0] == o;
	endproperty
	AST_MISALIGN: assert property (p_vec(dw_misalign, 9'h038))
		else $error("misaligned write entry wrong");
	AST_RD_MISS: assert property (p_vec(dr_miss, 9'h060))
		else $error("read miss entry wrong");
	AST_WR_MISS: assert property (p_vec(dw_miss, 9'h070))
		else $error("write miss entry wrong");
	AST_RD_PROT: assert property (p_vec(dr_prot, 9'h03c))
		else $error("read protection entry wrong");
	AST_WR_PROT: assert property (p_vec(dw_prot, 9'h040))
		else $error("write protection entry wrong");
	AST_CLEAN: assert property (p_vec(dw_clean, 9'h044))
		else $error("clean page entry wrong");
	AST_FPU: assert property (p_vec(fpu_error, 9'h02c))
		else $error("floating point entry wrong");
	AST_COP: assert property (p_vec(cop_issue && !cop_ack, 9'h030))
		else $error("coprocessor entry wrong");
	AST_SCALL: assert property (p_vec(scall_exec, 9'h100))
		else $error("supervisor call entry wrong");
	AST_IRQ_FETCH: assert property ($fell(pipe_busy) |-> !pc_load [*4])
		else $error("handler reached before vector fetch");
	cover property (dw_misalign ##1 pc_load);
	cover property (scall_exec ##1 pc_load);
	cover property ($rose(shadow_ctx));
endmodule // ceu_top_sva
bind ceu_top ceu_top_sva chk (.pclk, .presetn, .dw_misalign, .dr_miss,
	.dw_miss, .dr_prot, .dw_prot, .dw_clean, .fpu_error, .cop_issue,
	.cop_ack, .scall_exec, .pipe_busy, .pc_load, .pc_target, .shadow_ctx);

/* test/cpu_exception_entry_unit_tb.sv */
`timescale 1ns/10ps
`include "ceu_regs.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
	$display("wrong value at %0t got %h exp %h", $time, a, e); end end
module cpu_exception_entry_unit_tb;
	localparam VB = 32'h8000_0000;
	logic pclk, presetn, psel, penable, pwrite, cop_cmd, cop_nak, hit;
	logic scall_exec, rets_exec, sysreg_is_bytecode, pipe_busy, nmi_req;
	logic pready, pslverr, pc_load, shadow_ctx, cop_issue, cop_ack;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, cur_pc, fail_addr, pc_target, irq_offset, q;
	logic [4:0] flag_bit;
	logic [6:0] dc;
	logic [13:0] iv;
	logic [3:0] irq_req, lvl_cmd;
	logic [8:0] ofs_t [8] = '{9'h038, 9'h060, 9'h070, 9'h03c, 9'h040,
		9'h044, 9'h02c, 9'h030};
	logic [7:0] gm_t = 8'hc0;
	int err_total = 0;
	int tests_run = 0;
	int n;
	ceu_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .cur_pc, .fail_addr,
		.dw_misalign(dc[0]), .dr_miss(dc[1]), .dw_miss(dc[2]),
		.dr_prot(dc[3]), .dw_prot(dc[4]), .dw_clean(dc[5]),
		.fpu_error(dc[6]), .cop_issue, .cop_ack, .scall_exec, .rets_exec,
		.ins_cache(iv[0]), .ins_entry_read(iv[1]), .ins_entry_write(iv[2]),
		.ins_entry_search(iv[3]), .ins_mtdr(iv[4]), .ins_mfdr(iv[5]),
		.ins_rete(iv[6]), .ins_rets(iv[7]), .ins_retd(iv[8]),
		.ins_sleep(iv[9]), .ins_csrf(iv[10]), .ins_ssrf(iv[11]),
		.ins_mtsr(iv[12]), .ins_mfsr(iv[13]), .flag_bit,
		.sysreg_is_bytecode, .irq_req, .nmi_req, .irq_offset, .pipe_busy,
		.pc_load, .pc_target, .shadow_ctx);
	ceu_partner far (.pclk, .presetn, .lvl_cmd, .cop_cmd, .cop_nak,
		.irq_req, .nmi_req, .irq_offset, .cop_issue, .cop_ack);
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task final_report;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge pclk);
		err_total++;
		final_report;
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK({pslverr, q}, {1'b0, e})
	endtask
	// Holds the given causes for one cycle and samples the entry pulse after it.
	task fire(input logic [7:0] c, input logic [13:0] i, input logic [1:0] s,
		input logic [31:0] pc);
		@(posedge pclk);
		dc <= c[6:0];
		cop_cmd <= c[7];
		cop_nak <= c[7];
		iv <= i;
		scall_exec <= s[0];
		rets_exec <= s[1];
		cur_pc <= pc;
		@(posedge pclk);
		dc <= 7'h0;
		cop_cmd <= 1'b0;
		iv <= 14'h0;
		scall_exec <= 1'b0;
		rets_exec <= 1'b0;
		@(negedge pclk);
		hit = pc_load;
	endtask
	initial
	begin
		{presetn, psel, penable, pwrite, cop_cmd, cop_nak} = 6'h0;
		{scall_exec, rets_exec, sysreg_is_bytecode, pipe_busy} = 4'h0;
		{paddr, pwdata, cur_pc, fail_addr, flag_bit, dc, iv} = 0;
		lvl_cmd = 4'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		`CHK({pc_load, shadow_ctx, pc_target}, 34'h0)
		rd(`CEU_A_STATUS, `CEU_SR_RESET);
		apb(1'b1, `CEU_A_VBASE, VB);
		apb(1'b1, 12'h0fc, 32'h5);
		rd(12'h0fc, 32'h0);
		$display("reset and map test done");
		// ****************************************
		// Data-side, floating-point, coprocessor, privilege and supervisor call causes
		// ****************************************
		for (int r = 0; r < 8; r++)
		begin
			apb(1'b1, `CEU_A_STATUS, 32'h0);
			apb(1'b1, `CEU_A_EHIGH, 32'h2);
			fail_addr <= 32'h4567_8000 + r;
			fire(8'h1 << r, 14'h0, 2'b00, 32'h100 + 4 * r);
			`CHK({hit, pc_target}, {1'b1, VB | ofs_t[r]})
			rd(`CEU_A_STATUS, {7'h0, 3'h6, 1'b1, 4'h0, gm_t[r], 16'h0});
			rd(`CEU_A_EXCSR, 32'h0);
			rd(`CEU_A_EXCRA, 32'h100 + 4 * r);
			if (r < 6)
				rd(`CEU_A_FADDR, 32'h4567_8000 + r);
			if (r < 6)
				rd(`CEU_A_EHIGH, r == 0 ? 32'h4567_8002 : 32'h4567_8000);
			$display("cause test %0d done", r);
		end
		flag_bit <= 5'd16;
		for (int i = 0; i < 14; i++)
		begin
			apb(1'b1, `CEU_A_STATUS, 32'h0);
			fire(8'h0, 14'h1 << i, 2'b00, 32'h200);
			`CHK({hit, pc_target}, {1'b1, VB | 32'h28})
			rd(`CEU_A_STATUS, 32'h01a1_0000);
		end
		apb(1'b1, `CEU_A_STATUS, 32'h0);
		flag_bit <= 5'd5;
		sysreg_is_bytecode <= 1'b1;
		fire(8'h0, 14'h3c00, 2'b00, 32'h200);
		`CHK(hit, 1'b0)
		apb(1'b1, `CEU_A_STATUS, 32'h0040_0000);
		fire(8'h0, 14'h1, 2'b00, 32'h200);
		`CHK(hit, 1'b0)
		$display("privilege test done");
		apb(1'b1, `CEU_A_STATUS, 32'h0);
		fire(8'h0, 14'h0, 2'b01, 32'h300);
		`CHK({hit, pc_target}, {1'b1, VB | 32'h100})
		rd(`CEU_A_SUPRA, 32'h302);
		rd(`CEU_A_SUPSR, 32'h0);
		rd(`CEU_A_STATUS, 32'h0040_0000);
		fire(8'h0, 14'h0, 2'b10, 32'h400);
		`CHK({hit, pc_target}, {1'b1, 32'h302})
		apb(1'b1, `CEU_A_STATUS, 32'h0180_0000);
		fire(8'h0, 14'h0, 2'b01, 32'h500);
		`CHK({hit, pc_target}, {1'b1, VB | 32'h100})
		rd(`CEU_A_LINK, 32'h502);
		rd(`CEU_A_STATUS, 32'h0180_0000);
		$display("supervisor call test done");
		// ****************************************
		// Interrupt entry and masking
		// ****************************************
		apb(1'b1, `CEU_A_STATUS, 32'h0);
		pipe_busy <= 1'b1;
		lvl_cmd <= 4'h8;
		n = 0;
		repeat (20) @(negedge pclk) n += pc_load;
		`CHK(n, 0)
		@(posedge pclk);
		pipe_busy <= 1'b0;
		n = 0;
		while (pc_load !== 1'b1 && n < 30)
		begin
			@(negedge pclk);
			n++;
		end
		`CHK((n >= 4 && n <= 8), 1'b1)
		`CHK({pc_target, shadow_ctx}, {VB | 32'h230, 1'b1})
		@(posedge pclk);
		lvl_cmd <= 4'h0;
		rd(`CEU_A_STATUS, 32'h015e_0000);
		for (int m = 0; m < 2; m++)
		begin
			apb(1'b1, `CEU_A_STATUS, m ? 32'h0002_0000 : 32'h0001_0000);
			lvl_cmd <= 4'h1;
			n = 0;
			repeat (20) @(negedge pclk) n += pc_load;
			`CHK(n, 0)
			@(posedge pclk);
			lvl_cmd <= 4'h0;
		end
		$display("interrupt test done");
		// A second reset in mid-run must drop the shadow context again.
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		`CHK({pc_load, shadow_ctx, pc_target}, 34'h0)
		presetn <= 1'b1;
		rd(`CEU_A_STATUS, `CEU_SR_RESET);
		$display("mid-run reset test done");
		final_report;
	end
endmodule // cpu_exception_entry_unit_tb
